// ---- brc_defs.svh ----
`ifndef BRC_DEFS_SVH
`define BRC_DEFS_SVH
`define BRC_ADDR_W 15
`define BRC_MEM_DEPTH 32768
`define BRC_ADDR_CTRL 15'h7FF8
`define BRC_ADDR_SEC 15'h7FF9
`define BRC_ADDR_MIN 15'h7FFA
`define BRC_ADDR_HOUR 15'h7FFB
`define BRC_ADDR_DAY 15'h7FFC
`define BRC_ADDR_DATE 15'h7FFD
`define BRC_ADDR_MONTH 15'h7FFE
`define BRC_ADDR_YEAR 15'h7FFF
`define BRC_BIT_LOAD_HOLD 7
`define BRC_BIT_SNAP_HOLD 6
`define BRC_BIT_CAL_SIGN 5
`define BRC_BIT_HALT 7
`define BRC_BIT_FREQ_PROBE 6
`define BRC_BIT_CENT_EN 5
`define BRC_BIT_CENT 4
`define BRC_RST_CTRL 8'h00
`define BRC_RST_HALT 1'b1
`define BRC_OSC_HZ 17'd32768
`define BRC_CAL_SHORTEN 17'd128
`define BRC_CAL_LENGTHEN 17'd256
`define BRC_CAL_CYCLE_MIN 6'd63
`define BRC_CAL_MAX_MIN 7'd62
`define BRC_PROBE_HZ 17'd512
`define BRC_PROBE_HALF 6'd32
`endif

// ---- brc_pkg.sv ----
package brc_pkg;
  typedef struct packed {
    logic cent;
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] date;
    logic [2:0] day;
    logic [5:0] hour;
    logic [6:0] min;
    logic [6:0] sec;
  } brc_time_t;
  typedef struct packed {
    logic [14:0] addr;
    logic [7:0] data;
  } brc_wr_t;
endpackage

// ---- brc_clock.sv ----
`timescale 1ns/100ps
`include "brc_defs.svh"
// Operation
// - snapshot-hold bit set stops copying counters into visible registers
// - held registers keep time current at hold; counters keep running
// - all visible registers update in one cycle; update finishes first
// - after snapshot-hold clears, next refresh comes within one second
// - load-hold bit set freezes visible updates for software loading
// - load-hold cleared copies seven time bytes into counters
// - after load-hold clears, next clock update within one second
// - 24-hour BCD fields with documented ranges and tens/units split
// - seconds MSB halts oscillator when 1, runs it when 0
// - oscillator runs again within one second after halt cleared
// - one-second count divides the 32768 Hz crystal clock
// - control bits 4-0 calibration magnitude, bit 5 direction
// - correction acts at divide-by-256 stage: split or blank pulses
// - 64-minute cycle; one second per minute shortened 128 or lengthened 256
// - magnitude N modifies first 2N minutes of each cycle only
// - probe bit and running oscillator: data line zero 512 Hz on seconds read
// - probe rate independent of calibration setting
// - probe bit cleared automatically at power-down
// - century flag inverts at year rollover when toggle enabled
// - century flag writable only under load-hold; enable writable except while power-down is asserted
module brc_clock (
  input wire logic clk,
  input wire logic reset,
  input wire logic [14:0] addr,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  input wire logic chip_en_n,
  input wire logic write_en_n,
  input wire logic out_en_n,
  input wire logic osc_in,
  input wire logic power_down
);

  function automatic logic [7:0] brc_bcd_inc(input logic [7:0] v,
                                            input logic [7:0] last,
                                            input logic [7:0] first);
    logic [7:0] r;
    r = 8'h00;
    if (v == last) begin
      r = first;
    end else if (v[3:0] == 4'h9) begin
      r = {v[7:4] + 4'h1, 4'h0};
    end else begin
      r = {v[7:4], v[3:0] + 4'h1};
    end
    return r;
  endfunction

  function automatic logic [7:0] brc_month_last(input logic [7:0] mon,
                                               input logic [7:0] yr);
    logic leap;
    logic [7:0] r;
    leap = (!yr[4] && (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 ||
            yr[3:0] == 4'h8)) || (yr[4] && (yr[3:0] == 4'h2 ||
            yr[3:0] == 4'h6));
    r = 8'h31;
    if (mon == 8'h02) begin
      r = leap ? 8'h29 : 8'h28;
    end else if (mon == 8'h04 || mon == 8'h06 || mon == 8'h09 ||
                 mon == 8'h11) begin
      r = 8'h30;
    end
    return r;
  endfunction

  // pin synchronisers
  logic [14:0] addr_m, addr_s;
  logic [7:0] din_m, din_s;
  logic [3:0] ctl_m, ctl_s;
  logic osc_m, osc_s, osc_d;
  logic pd_m, pd_s;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      addr_m <= 15'h0000;
      addr_s <= 15'h0000;
      din_m <= 8'h00;
      din_s <= 8'h00;
      ctl_m <= 4'hF;
      ctl_s <= 4'hF;
      osc_m <= 1'b0;
      osc_s <= 1'b0;
      osc_d <= 1'b0;
      pd_m <= 1'b0;
      pd_s <= 1'b0;
    end else begin
      addr_m <= addr;
      addr_s <= addr_m;
      din_m <= data_in;
      din_s <= din_m;
      ctl_m <= {chip_en_n, write_en_n, out_en_n, 1'b1};
      ctl_s <= ctl_m;
      osc_m <= osc_in;
      osc_s <= osc_m;
      osc_d <= osc_s;
      pd_m <= power_down;
      pd_s <= pd_m;
    end
  end

  logic ce_n_s, we_n_s, oe_n_s;
  assign ce_n_s = ctl_s[3];
  assign we_n_s = ctl_s[2];
  assign oe_n_s = ctl_s[1];

  // host write capture: commit at end of the low-low window
  logic wr_act, wr_act_d;
  brc_pkg::brc_wr_t wr_hold;
  logic wr_commit;
  assign wr_act = !ce_n_s && !we_n_s;
  assign wr_commit = wr_act_d && !wr_act;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_act_d <= 1'b0;
      wr_hold <= '0;
    end else begin
      wr_act_d <= wr_act;
      if (wr_act) begin
        wr_hold <= '{addr: addr_s, data: din_s};
      end
    end
  end

  // plain memory below the clock bytes
  logic [7:0] mem [0:`BRC_MEM_DEPTH-1];
  logic is_clk_wr;
  assign is_clk_wr = wr_hold.addr >= `BRC_ADDR_CTRL;

  always_ff @(posedge clk) begin
    if (wr_commit && !is_clk_wr) begin
      mem[wr_hold.addr] <= wr_hold.data;
    end
  end

  // host-owned control bits
  logic [7:0] ctrl;
  logic halt, probe_en, cent_en, load_d;
  logic load_hold, snap_hold, hold;
  assign load_hold = ctrl[`BRC_BIT_LOAD_HOLD];
  assign snap_hold = ctrl[`BRC_BIT_SNAP_HOLD];
  assign hold = load_hold || snap_hold;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl <= `BRC_RST_CTRL;
    end else if (wr_commit && wr_hold.addr == `BRC_ADDR_CTRL) begin
      ctrl <= wr_hold.data;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      halt <= `BRC_RST_HALT;
    end else if (wr_commit && wr_hold.addr == `BRC_ADDR_SEC) begin
      halt <= wr_hold.data[`BRC_BIT_HALT];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      probe_en <= 1'b0;
      cent_en <= 1'b0;
    end else if (pd_s) begin
      probe_en <= 1'b0;
    end else if (wr_commit && wr_hold.addr == `BRC_ADDR_DAY) begin
      probe_en <= wr_hold.data[`BRC_BIT_FREQ_PROBE];
      cent_en <= wr_hold.data[`BRC_BIT_CENT_EN];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      load_d <= 1'b0;
    end else begin
      load_d <= load_hold;
    end
  end

  logic load_release;
  assign load_release = load_d && !load_hold;

  // crystal edges, gated by halt; restart is immediate
  logic osc_tick;
  assign osc_tick = osc_s && !osc_d && !halt;

  // running counters and calibration
  brc_pkg::brc_time_t cnt, vis, next_cnt;
  logic [16:0] presc;
  logic [5:0] cal_min;
  logic [16:0] sec_len;
  logic [6:0] cal_span;
  logic cal_active, sec_tick;

  assign cal_span = {1'b0, ctrl[4:0], 1'b0};
  assign cal_active = cnt.sec == 7'h00 && {1'b0, cal_min} < cal_span &&
                      {1'b0, cal_min} < `BRC_CAL_MAX_MIN;

  always_comb begin
    sec_len = `BRC_OSC_HZ;
    if (cal_active) begin
      if (ctrl[`BRC_BIT_CAL_SIGN]) begin
        sec_len = `BRC_OSC_HZ - `BRC_CAL_SHORTEN;
      end else begin
        sec_len = `BRC_OSC_HZ + `BRC_CAL_LENGTHEN;
      end
    end
  end

  assign sec_tick = osc_tick && (presc == sec_len - 17'd1);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      presc <= 17'h00000;
    end else if (load_release) begin
      presc <= 17'h00000;
    end else if (osc_tick) begin
      presc <= sec_tick ? 17'h00000 : presc + 17'd1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cal_min <= 6'h00;
    end else if (sec_tick && cnt.sec == 7'h59) begin
      cal_min <= cal_min == `BRC_CAL_CYCLE_MIN ? 6'h00 :
                 cal_min + 6'd1;
    end
  end

  // one-second advance of the BCD counters
  logic [7:0] t_sec, t_min, t_hour, t_date, t_mon, t_year;
  always_comb begin
    next_cnt = cnt;
    t_sec = brc_bcd_inc({1'b0, cnt.sec}, 8'h59, 8'h00);
    t_min = brc_bcd_inc({1'b0, cnt.min}, 8'h59, 8'h00);
    t_hour = brc_bcd_inc({2'b00, cnt.hour}, 8'h23, 8'h00);
    t_date = brc_bcd_inc(cnt.date,
                         brc_month_last(cnt.month, cnt.year), 8'h01);
    t_mon = brc_bcd_inc(cnt.month, 8'h12, 8'h01);
    t_year = brc_bcd_inc(cnt.year, 8'h99, 8'h00);
    next_cnt.sec = t_sec[6:0];
    if (cnt.sec == 7'h59) begin
      next_cnt.min = t_min[6:0];
      if (cnt.min == 7'h59) begin
        next_cnt.hour = t_hour[5:0];
        if (cnt.hour == 6'h23) begin
          next_cnt.day = cnt.day == 3'h7 ? 3'h1 : cnt.day + 3'h1;
          next_cnt.date = t_date;
          if (cnt.date == brc_month_last(cnt.month, cnt.year)) begin
            next_cnt.month = t_mon;
            if (cnt.month == 8'h12) begin
              next_cnt.year = t_year;
              if (cnt.year == 8'h99 && cent_en) begin
                next_cnt.cent = !cnt.cent;
              end
            end
          end
        end
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt <= '{cent: 1'b0, year: 8'h00, month: 8'h01, date: 8'h01,
               day: 3'h1, hour: 6'h00, min: 7'h00, sec: 7'h00};
    end else if (load_release) begin
      cnt <= vis;
    end else if (sec_tick) begin
      cnt <= next_cnt;
    end
  end

  // visible registers: refresh in one step, or host write
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      vis <= '{cent: 1'b0, year: 8'h00, month: 8'h01, date: 8'h01,
               day: 3'h1, hour: 6'h00, min: 7'h00, sec: 7'h00};
    end else if (sec_tick && !hold && !load_release) begin
      vis <= next_cnt;
    end else if (wr_commit) begin
      unique case (wr_hold.addr)
        `BRC_ADDR_SEC: vis.sec <= wr_hold.data[6:0];
        `BRC_ADDR_MIN: vis.min <= wr_hold.data[6:0];
        `BRC_ADDR_HOUR: vis.hour <= wr_hold.data[5:0];
        `BRC_ADDR_DAY: begin
          vis.day <= wr_hold.data[2:0];
          if (load_hold) begin
            vis.cent <= wr_hold.data[`BRC_BIT_CENT];
          end
        end
        `BRC_ADDR_DATE: vis.date <= {2'b00, wr_hold.data[5:0]};
        `BRC_ADDR_MONTH: vis.month <= {3'b000, wr_hold.data[4:0]};
        `BRC_ADDR_YEAR: vis.year <= wr_hold.data;
        default: vis <= vis;
      endcase
    end
  end

  // probe square wave from the uncorrected crystal edges
  logic [5:0] probe_cnt;
  logic probe_wave;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      probe_cnt <= 6'h00;
      probe_wave <= 1'b0;
    end else if (osc_tick) begin
      if (probe_cnt == `BRC_PROBE_HALF - 6'd1) begin
        probe_cnt <= 6'h00;
        probe_wave <= !probe_wave;
      end else begin
        probe_cnt <= probe_cnt + 6'd1;
      end
    end
  end

  // read path
  logic [7:0] rd_byte;
  always_comb begin
    unique case (addr_s)
      `BRC_ADDR_CTRL: rd_byte = ctrl;
      `BRC_ADDR_SEC: begin
        rd_byte = {halt, vis.sec};
        if (probe_en && !halt) begin
          rd_byte[0] = probe_wave;
        end
      end
      `BRC_ADDR_MIN: rd_byte = {1'b0, vis.min};
      `BRC_ADDR_HOUR: rd_byte = {2'b00, vis.hour};
      `BRC_ADDR_DAY: rd_byte = {1'b0, probe_en, cent_en, vis.cent,
                                1'b0, vis.day};
      `BRC_ADDR_DATE: rd_byte = vis.date;
      `BRC_ADDR_MONTH: rd_byte = vis.month;
      `BRC_ADDR_YEAR: rd_byte = vis.year;
      default: rd_byte = mem[addr_s];
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      data_out <= 8'h00;
    end else begin
      data_out <= rd_byte;
    end
  end

  assign data_oe = !ce_n_s && !oe_n_s && we_n_s;

endmodule

// ---- brc_clock_properties.sv ----
`timescale 1ns/100ps
module brc_clock_properties (
  input wire logic clk,
  input wire logic reset,
  input wire logic [14:0] addr,
  input wire logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  input wire logic chip_en_n,
  input wire logic write_en_n,
  input wire logic out_en_n,
  input wire logic osc_in,
  input wire logic power_down
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  chk_oe_follow: assert property (
    data_oe == (!$past(chip_en_n, 2) && !$past(out_en_n, 2)
    && $past(write_en_n, 2))) else $error("drive not from strobes");
  chk_oe_write_off: assert property (
    !write_en_n |-> ##2 !data_oe) else $error("driving in write");
  chk_oe_read_on: assert property (
    (!chip_en_n && !out_en_n && write_en_n) [*3] |-> data_oe)
    else $error("read not driven");
  chk_min_bcd: assert property (
    (addr == 15'h7FFA) [*5] |-> !data_out[7] && data_out[6:4] <= 3'h5
    && data_out[3:0] <= 4'h9) else $error("minutes out of range");
  chk_hour_bcd: assert property (
    (addr == 15'h7FFB) [*5] |-> data_out <= 8'h23
    && data_out[3:0] <= 4'h9) else $error("hours out of range");
  chk_day_fields: assert property (
    (addr == 15'h7FFC) [*5] |-> !data_out[7] && !data_out[3]
    && data_out[2:0] != 3'h0) else $error("day out of range");
  chk_date_bcd: assert property (
    (addr == 15'h7FFD) [*5] |-> data_out >= 8'h01 && data_out <= 8'h31
    && data_out[3:0] <= 4'h9) else $error("date out of range");
  chk_month_range: assert property (
    (addr == 15'h7FFE) [*5] |-> data_out >= 8'h01 && data_out <= 8'h12
    && data_out[3:0] <= 4'h9) else $error("month out of range");
endmodule
bind brc_clock brc_clock_properties u_props (.clk(clk), .reset(reset),
  .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
  .chip_en_n(chip_en_n), .write_en_n(write_en_n), .out_en_n(out_en_n),
  .osc_in(osc_in), .power_down(power_down));

// ---- brc_host_model.sv ----
`timescale 1ns/100ps
module brc_host_model (
  input wire logic clk,
  input wire logic [7:0] data_out,
  output logic [14:0] addr,
  output logic [7:0] data_in,
  output logic chip_en_n,
  output logic write_en_n,
  output logic out_en_n
);
  initial begin
    addr = 15'h7FF8;
    data_in = 8'h00;
    chip_en_n = 1'b1;
    write_en_n = 1'b1;
    out_en_n = 1'b1;
  end
  // one bus cycle; afterwards address and data lines show the inverse of their last value
  task automatic cyc(input logic [14:0] a, input logic [7:0] d,
      input logic wr, output logic [7:0] q);
    @(posedge clk);
    #1;
    addr = a;
    data_in = d;
    chip_en_n = 1'b0;
    write_en_n = !wr;
    out_en_n = wr;
    repeat (4) @(posedge clk);
    #1;
    q = data_out;
    chip_en_n = 1'b1;
    write_en_n = 1'b1;
    out_en_n = 1'b1;
    @(posedge clk);
    #1;
    addr = ~a;
    data_in = ~d;
    repeat (3) @(posedge clk);
  endtask
endmodule

// ---- brc_clock_tb.sv ----
`timescale 1ns/100ps
module brc_clock_tb;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic osc_in = 1'b0;
  logic power_down = 1'b0;
  logic [14:0] addr;
  logic [7:0] data_in;
  logic [7:0] data_out;
  logic [7:0] q;
  logic [1:0] b;
  logic data_oe;
  logic chip_en_n;
  logic write_en_n;
  logic out_en_n;
  int n_fail = 0;
  int check_count = 0;
  logic [31:0] rs = 32'hB4FE;
  logic [7:0] mdl [int];
  logic [7:0] rv [8] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h01, 8'h01,
    8'h01, 8'h00};
  // fixed-zero bits all written as zero, day bit 3 included; day carries probe bit on purpose
  logic [7:0] tm [7] = '{8'h59, 8'h59, 8'h23, 8'h77, 8'h31, 8'h12, 8'h99};
  logic [7:0] nx [7] = '{8'h00, 8'h00, 8'h00, 8'h21, 8'h01, 8'h01, 8'h00};
  always #25 clk = ~clk;
  always @(posedge clk) osc_in <= #1 ~osc_in;
  brc_clock u_dut (.clk(clk), .reset(reset), .addr(addr),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .chip_en_n(chip_en_n), .write_en_n(write_en_n),
    .out_en_n(out_en_n), .osc_in(osc_in), .power_down(power_down));
  brc_host_model u_host (.clk(clk), .data_out(data_out), .addr(addr),
    .data_in(data_in), .chip_en_n(chip_en_n), .write_en_n(write_en_n),
    .out_en_n(out_en_n));
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    u_host.cyc(a, d, 1'b1, q);
  endtask
  task automatic rd_chk(input logic [14:0] a);
    u_host.cyc(a, 8'h00, 1'b0, q);
    check(q, mdl[a]);
  endtask
  task automatic chk_regs();
    for (int i = 0; i < 8; i++) begin
      rd_chk(15'h7FF8 + 15'(i));
    end
  endtask
  task automatic end_of_test();
    if (n_fail == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clk);
    n_fail++;
    end_of_test();
  end
  initial begin
    int a;
    for (int i = 0; i < 8; i++) begin
      mdl[32760 + i] = rv[i];
    end
    repeat (20) @(posedge clk);
    #1;
    reset = 1'b0;
    repeat (3) @(posedge clk);
    chk_regs();
    for (int i = 0; i < 4; i++) begin
      a = int'(rnd() % 32'h7FF8);
      mdl[a] = 8'(rnd());
      wr(a[14:0], mdl[a]);
      rd_chk(a[14:0]);
    end
    wr(15'h7FFC, 8'h37);
    mdl[32764] = 8'h27;
    rd_chk(15'h7FFC);
    wr(15'h7FF8, 8'h80);
    mdl[32760] = 8'h80;
    for (int i = 0; i < 7; i++) begin
      wr(15'h7FF9 + 15'(i), tm[i]);
      mdl[32761 + i] = tm[i];
    end
    b = 2'b00;
    for (int i = 0; i < 16; i++) begin
      u_host.cyc(15'h7FF9, 8'h00, 1'b0, q);
      check({1'b0, q[7:1]}, 8'h2C);
      if (q[0] === 1'b1) begin
        b[1] = 1'b1;
      end else if (q[0] === 1'b0) begin
        b[0] = 1'b1;
      end
    end
    check({6'h00, b}, 8'h03);
    @(posedge clk);
    #1;
    power_down = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    power_down = 1'b0;
    mdl[32764] = 8'h37;
    chk_regs();
    wr(15'h7FF8, 8'h3F);
    mdl[32760] = 8'h3F;
    repeat (60000) @(posedge clk);
    rd_chk(15'h7FF9);
    a = 0;
    while (q === 8'h59 && a < 1000) begin
      u_host.cyc(15'h7FF9, 8'h00, 1'b0, q);
      a++;
    end
    if (q === 8'h59) begin
      n_fail++;
      end_of_test();
    end
    for (int i = 0; i < 7; i++) begin
      mdl[32761 + i] = nx[i];
    end
    chk_regs();
    end_of_test();
  end
endmodule
